// ---- verilog/imxcs_pkg.sv ----
// package for the bonding control/status register bank
// assumes a 32-bit axi4-lite bus; offsets are register indices, byte address = 4 x index
package imxcs_pkg;
	localparam logic [7:0] IDX_QPTR_CLEAR = 8'h12;
	localparam logic [7:0] IDX_CONFIG = 8'h16;
	localparam logic [7:0] IDX_COMMAND = 8'h17;
	localparam logic [7:0] IDX_SYNC_STATUS = 8'h18;
	localparam logic [7:0] IDX_SYNC_IRQ_EN = 8'h19;
	localparam logic [7:0] IDX_SYNC_LATCHED = 8'h1a;
	localparam logic [7:0] IDX_SKEW = 8'h1b;
	localparam logic [7:0] IDX_SKEW_IRQ_EN = 8'h1c;
	localparam logic [7:0] IDX_SKEW_LATCHED = 8'h1d;
	localparam logic [7:0] IDX_FRAME_IRQ_EN = 8'h1e;
	localparam logic [7:0] IDX_FRAME_LATCHED = 8'h1f;
	localparam int BIT_READ_PTR_CLEAR = 1;
	localparam int BIT_WRITE_PTR_CLEAR = 0;
	localparam int BIT_LINE_STANDARD = 6;
	localparam int BIT_RECEIVE_EN = 5;
	localparam int BIT_SEND_EN = 4;
	localparam int BIT_FAR_SYNC_LO = 4;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_COMMAND = 8'hff;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] CMD_NOP = 8'hff;
	localparam logic [7:0] CMD_LINK_START = 8'h82;
	localparam int SKEW_FULL_SCALE_US = 64000;
	localparam int SKEW_LIMIT_US = 7750;
	// 8-bit code covers 64 ms; limit in code steps, rounded down
	localparam logic [7:0] SKEW_LIMIT_CODE = 8'((SKEW_LIMIT_US * 256) / SKEW_FULL_SCALE_US);
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef struct packed {
		logic line_standard_e1;
		logic receive_path_enable;
		logic send_path_enable;
		logic [3:0] member_links;
	} imxcs_ctrl_t;
	typedef struct packed {
		logic [3:0] far_end_sync;
		logic [3:0] local_sync;
		logic [3:0] far_frame_loss;
		logic [3:0] local_frame_loss;
		logic [7:0] measured_skew;
	} imxcs_status_t;
endpackage

// ---- verilog/imxcs_top.sv ----
// register bank for the four-link inverse multiplexer: config, command, sync,
// skew and frame-loss status with latched bits and an interrupt request.
// assumes an axi4-lite master on clk_sys and status levels synchronous to clk_sys.
// Functional notes
// - writing bit1 clears transmit queue read pointer
// - writing bit0 clears transmit queue write pointer
// - config bit6 selects t1 or e1
// - config bit5 gates received data to processor
// - config bit4 gates serial transmit data
// - config bits3..0 select member links four..one
// - command resets to ff; 82h starts link
// - link start makes far end seek sequence
// - other command codes are ignored
// - status bits7..4 show far end sync
// - status bits3..0 show local sync
// - each sync bit has a latched copy
// - sync enable bits gate latched sync bits
// - skew reported as 8 bits, 64 ms span
// - skew over 7.75 ms latches error bit
// - skew enable bit0 gates latched error bit
// - frame enables gate far/local frame-loss bits
// - frame-loss latched bits set on out-of-frame
`timescale 1ns/1ps
`default_nettype none
module imxcs_top #(
	parameter int LINK_COUNT = 4 // member links served by the bank
) (
	input wire logic clk_sys, // 25 mhz system clock
	input wire logic rst_b, // async reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire imxcs_pkg::imxcs_status_t status_in, // live link status levels
	output imxcs_pkg::imxcs_ctrl_t ctrl_out, // mode, path and link selects
	output logic link_start_pulse, // one-cycle link start toward far end
	output logic txq_read_ptr_clear, // transmit queue read pointer clear
	output logic txq_write_ptr_clear, // transmit queue write pointer clear
	output logic irq // interrupt request, active high level
);
	import imxcs_pkg::*;

	// the control struct carries three mode bits plus one select per link
	if ($bits(imxcs_ctrl_t) != LINK_COUNT + 3) begin : g_link_check
		$error("link count does not fit the control struct");
	end

	logic [7:0] config_reg, command_reg, qptr_reg;
	logic [7:0] sync_status_reg, sync_irq_en_reg, sync_latched_reg;
	logic [7:0] skew_reg, skew_irq_en_reg, frame_irq_en_reg, frame_latched_reg;
	logic skew_latched_reg;
	logic [7:0] sync_latched_next, frame_latched_next, command_next;
	logic skew_latched_next;
	logic aw_held_reg, w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [7:0] w_data_reg;
	logic w_lane0_reg;

	// write channel: address and data taken independently, response after both
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	wire [7:0] wr_idx = {2'b00, aw_addr_reg[7:2]};
	wire wr_lane = w_lane0_reg;
	wire wr_cfg = wr_fire && wr_lane && wr_idx == IDX_CONFIG;
	wire wr_cmd = wr_fire && wr_lane && wr_idx == IDX_COMMAND;
	wire wr_qptr = wr_fire && wr_lane && wr_idx == IDX_QPTR_CLEAR;
	wire wr_sie = wr_fire && wr_lane && wr_idx == IDX_SYNC_IRQ_EN;
	wire wr_sle = wr_fire && wr_lane && wr_idx == IDX_SYNC_LATCHED;
	wire wr_kie = wr_fire && wr_lane && wr_idx == IDX_SKEW_IRQ_EN;
	wire wr_kle = wr_fire && wr_lane && wr_idx == IDX_SKEW_LATCHED;
	wire wr_fie = wr_fire && wr_lane && wr_idx == IDX_FRAME_IRQ_EN;
	wire wr_fle = wr_fire && wr_lane && wr_idx == IDX_FRAME_LATCHED;
	wire wr_mapped = wr_idx == IDX_CONFIG || wr_idx == IDX_COMMAND || wr_idx == IDX_QPTR_CLEAR
		|| (wr_idx >= IDX_SYNC_STATUS && wr_idx <= IDX_FRAME_LATCHED);

	// live status events
	wire [7:0] sync_now = {status_in.far_end_sync, status_in.local_sync};
	wire [7:0] frame_now = {status_in.far_frame_loss, status_in.local_frame_loss};
	wire skew_err_now = status_in.measured_skew > SKEW_LIMIT_CODE;

	// latched bits: write one to clear, a new event wins over the clear
	always_comb begin
		sync_latched_next = (sync_latched_reg & ~({8{wr_sle}} & w_data_reg)) | sync_now;
		frame_latched_next = (frame_latched_reg & ~({8{wr_fle}} & w_data_reg)) | frame_now;
		skew_latched_next = (skew_latched_reg & ~(wr_kle & w_data_reg[0])) | skew_err_now;
	end

	// only the two documented codes are kept; anything else leaves the register alone
	wire cmd_valid = w_data_reg == CMD_NOP || w_data_reg == CMD_LINK_START;
	assign command_next = (wr_cmd && cmd_valid) ? w_data_reg : command_reg;

	wire irq_next = |(sync_latched_reg & sync_irq_en_reg)
		|| (skew_latched_reg && skew_irq_en_reg[0])
		|| |(frame_latched_reg & frame_irq_en_reg);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 8'h00;
			w_lane0_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_held_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_data_reg <= s_axi_wdata[7:0];
				w_lane0_reg <= s_axi_wstrb[0];
				w_held_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			config_reg <= RST_CONFIG;
			command_reg <= RST_COMMAND;
			qptr_reg <= RST_ZERO;
			sync_irq_en_reg <= RST_ZERO;
			skew_irq_en_reg <= RST_ZERO;
			frame_irq_en_reg <= RST_ZERO;
		end else begin
			if (wr_cfg)
				config_reg <= {1'b0, w_data_reg[6:0]};
			command_reg <= command_next;
			if (wr_qptr)
				qptr_reg <= {6'b0, w_data_reg[1:0]};
			if (wr_sie)
				sync_irq_en_reg <= w_data_reg;
			if (wr_kie)
				skew_irq_en_reg <= {7'b0, w_data_reg[0]};
			if (wr_fie)
				frame_irq_en_reg <= w_data_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync_status_reg <= RST_ZERO;
			sync_latched_reg <= RST_ZERO;
			frame_latched_reg <= RST_ZERO;
			skew_latched_reg <= 1'b0;
			skew_reg <= RST_ZERO;
			irq <= 1'b0;
		end else begin
			sync_status_reg <= sync_now;
			sync_latched_reg <= sync_latched_next;
			frame_latched_reg <= frame_latched_next;
			skew_latched_reg <= skew_latched_next;
			skew_reg <= status_in.measured_skew;
			irq <= irq_next;
		end
	end

	// control outputs, each from its own flop
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_out <= '0;
			link_start_pulse <= 1'b0;
			txq_read_ptr_clear <= 1'b0;
			txq_write_ptr_clear <= 1'b0;
		end else begin
			ctrl_out.line_standard_e1 <= wr_cfg ? w_data_reg[BIT_LINE_STANDARD]
				: config_reg[BIT_LINE_STANDARD];
			ctrl_out.receive_path_enable <= wr_cfg ? w_data_reg[BIT_RECEIVE_EN]
				: config_reg[BIT_RECEIVE_EN];
			ctrl_out.send_path_enable <= wr_cfg ? w_data_reg[BIT_SEND_EN]
				: config_reg[BIT_SEND_EN];
			ctrl_out.member_links <= wr_cfg ? w_data_reg[3:0] : config_reg[3:0];
			// pulse per accepted write so a repeated start is seen again
			link_start_pulse <= wr_cmd && w_data_reg == CMD_LINK_START;
			txq_read_ptr_clear <= wr_qptr ? w_data_reg[BIT_READ_PTR_CLEAR]
				: qptr_reg[BIT_READ_PTR_CLEAR];
			txq_write_ptr_clear <= wr_qptr ? w_data_reg[BIT_WRITE_PTR_CLEAR]
				: qptr_reg[BIT_WRITE_PTR_CLEAR];
		end
	end

	// read channel: one outstanding read, answer one cycle after the address
	wire [7:0] rd_idx = {2'b00, s_axi_araddr[7:2]};
	logic [7:0] rd_byte;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		case (rd_idx)
			IDX_QPTR_CLEAR: rd_byte = qptr_reg;
			IDX_CONFIG: rd_byte = config_reg;
			IDX_COMMAND: rd_byte = command_reg;
			IDX_SYNC_STATUS: rd_byte = sync_status_reg;
			IDX_SYNC_IRQ_EN: rd_byte = sync_irq_en_reg;
			IDX_SYNC_LATCHED: rd_byte = sync_latched_reg;
			IDX_SKEW: rd_byte = skew_reg;
			IDX_SKEW_IRQ_EN: rd_byte = skew_irq_en_reg;
			IDX_SKEW_LATCHED: rd_byte = {7'b0, skew_latched_reg};
			IDX_FRAME_IRQ_EN: rd_byte = frame_irq_en_reg;
			IDX_FRAME_LATCHED: rd_byte = frame_latched_reg;
			default: begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_byte};
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// checks
	property p_cmd_reset;
		@(posedge clk_sys) $rose(rst_b) |-> command_reg == CMD_NOP;
	endproperty
	a_cmd_reset: assert property (p_cmd_reset) else $error("command not ff after reset");

	property p_cmd_ignore;
		@(posedge clk_sys) disable iff (!rst_b) wr_cmd && !cmd_valid |=> $stable(command_reg);
	endproperty
	a_cmd_ignore: assert property (p_cmd_ignore) else $error("bad command code stored");

	property p_start_pulse;
		@(posedge clk_sys) disable iff (!rst_b)
			wr_cmd && w_data_reg == CMD_LINK_START |=> link_start_pulse ##1 !link_start_pulse;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("link start pulse wrong");

	property p_sync_hold;
		@(posedge clk_sys) disable iff (!rst_b)
			sync_latched_reg[0] && !(wr_sle && w_data_reg[0]) |=> sync_latched_reg[0];
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync latch dropped");

	property p_frame_set;
		@(posedge clk_sys) disable iff (!rst_b) frame_now[7] |=> frame_latched_reg[7];
	endproperty
	a_frame_set: assert property (p_frame_set) else $error("frame loss not latched");

	property p_skew_err;
		@(posedge clk_sys) disable iff (!rst_b)
			status_in.measured_skew > SKEW_LIMIT_CODE |=> skew_latched_reg;
	endproperty
	a_skew_err: assert property (p_skew_err) else $error("skew error not latched");

	property p_irq_sync;
		@(posedge clk_sys) disable iff (!rst_b)
			(sync_latched_reg[4] && sync_irq_en_reg[4]) |=> irq;
	endproperty
	a_irq_sync: assert property (p_irq_sync) else $error("sync irq missing");

	property p_irq_quiet;
		@(posedge clk_sys) disable iff (!rst_b)
			!(|(sync_latched_reg & sync_irq_en_reg)) && !(skew_latched_reg && skew_irq_en_reg[0])
				&& !(|(frame_latched_reg & frame_irq_en_reg)) |=> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq without cause");

	property p_send_follow;
		@(posedge clk_sys) disable iff (!rst_b)
			wr_cfg |=> ctrl_out.send_path_enable == $past(w_data_reg[BIT_SEND_EN])
				&& ctrl_out.member_links == $past(w_data_reg[3:0]);
	endproperty
	a_send_follow: assert property (p_send_follow) else $error("config not applied");

	property p_rptr;
		@(posedge clk_sys) disable iff (!rst_b)
			wr_qptr && w_data_reg[1] |=> txq_read_ptr_clear [*2];
	endproperty
	a_rptr: assert property (p_rptr) else $error("read pointer clear not held");

	property p_wptr;
		@(posedge clk_sys) disable iff (!rst_b)
			wr_qptr && w_data_reg[0] |=> txq_write_ptr_clear [*2];
	endproperty
	a_wptr: assert property (p_wptr) else $error("write pointer clear not held");

	property p_line_std;
		@(posedge clk_sys) disable iff (!rst_b)
			wr_cfg |=> ctrl_out.line_standard_e1 == $past(w_data_reg[BIT_LINE_STANDARD]);
	endproperty
	a_line_std: assert property (p_line_std) else $error("line standard not applied");

	property p_receive_follow;
		@(posedge clk_sys) disable iff (!rst_b)
			wr_cfg |=> ctrl_out.receive_path_enable == $past(w_data_reg[BIT_RECEIVE_EN]);
	endproperty
	a_receive_follow: assert property (p_receive_follow) else $error("receive gate wrong");

	// exactly at the limit is still no error
	property p_skew_quiet;
		@(posedge clk_sys) disable iff (!rst_b)
			!skew_latched_reg && status_in.measured_skew <= SKEW_LIMIT_CODE |=> !skew_latched_reg;
	endproperty
	a_skew_quiet: assert property (p_skew_quiet) else $error("false skew error");

	property p_skew_irq;
		@(posedge clk_sys) disable iff (!rst_b)
			skew_latched_reg && skew_irq_en_reg[0] |=> irq;
	endproperty
	a_skew_irq: assert property (p_skew_irq) else $error("skew irq missing");

	property p_cmd_nop;
		@(posedge clk_sys) disable iff (!rst_b)
			wr_cmd && w_data_reg == CMD_NOP |=> command_reg == CMD_NOP && !link_start_pulse;
	endproperty
	a_cmd_nop: assert property (p_cmd_nop) else $error("nop code acted on");

	property p_regs_reset;
		@(posedge clk_sys) $rose(rst_b) |-> config_reg == RST_CONFIG && ctrl_out == '0 && !irq
			&& sync_latched_reg == RST_ZERO && frame_latched_reg == RST_ZERO;
	endproperty
	a_regs_reset: assert property (p_regs_reset) else $error("register not at default");

	// per link: local half of each status byte low, far half high
	for (genvar i = 0; i < LINK_COUNT; i++) begin : g_link_chk
		property p_lsync;
			@(posedge clk_sys) disable iff (!rst_b)
				status_in.local_sync[i] |=> sync_status_reg[i] && sync_latched_reg[i];
		endproperty
		a_lsync: assert property (p_lsync) else $error("local sync not shown");
		property p_fsync;
			@(posedge clk_sys) disable iff (!rst_b)
				status_in.far_end_sync[i]
					|=> sync_status_reg[i + LINK_COUNT] && sync_latched_reg[i + LINK_COUNT];
		endproperty
		a_fsync: assert property (p_fsync) else $error("far sync not shown");
		property p_lframe;
			@(posedge clk_sys) disable iff (!rst_b)
				status_in.local_frame_loss[i] |=> frame_latched_reg[i];
		endproperty
		a_lframe: assert property (p_lframe) else $error("local frame loss not latched");
		property p_fr_irq;
			@(posedge clk_sys) disable iff (!rst_b)
				(frame_latched_reg[i] && frame_irq_en_reg[i])
					|| (frame_latched_reg[i + LINK_COUNT] && frame_irq_en_reg[i + LINK_COUNT]) |=> irq;
		endproperty
		a_fr_irq: assert property (p_fr_irq) else $error("frame irq missing");
	end
endmodule
`default_nettype wire

// ---- sim/imxcs_far_model.sv ----
// far-end bonding partner: syncs after a link start, reports skew and frame loss
// assumes skew and frame-loss commands from the bench, synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module imxcs_far_model #(
	parameter int SYNC_DLY = 4
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic link_start_pulse, // link start from the block
	input wire logic [3:0] member_links, // selected member links
	input wire logic [7:0] frame_cmd, // far loss 7:4, local loss 3:0
	input wire logic [7:0] skew_cmd, // skew code to report
	output imxcs_pkg::imxcs_status_t status_out // status levels toward the block
);
	import imxcs_pkg::*;
	logic [7:0] wait_reg;
	logic [3:0] sync_reg;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wait_reg <= 8'h00;
			sync_reg <= 4'h0;
		end else begin
			// sequence search takes a while; a link that leaves drops sync at once
			if (link_start_pulse) wait_reg <= 8'(SYNC_DLY);
			else if (wait_reg != 8'h00) wait_reg <= wait_reg - 8'h01;
			sync_reg <= (wait_reg == 8'h01) ? member_links : (sync_reg & member_links);
		end
	end
	assign status_out.far_end_sync = sync_reg;
	assign status_out.local_sync = sync_reg;
	assign status_out.far_frame_loss = frame_cmd[7:4];
	assign status_out.local_frame_loss = frame_cmd[3:0];
	assign status_out.measured_skew = skew_cmd;
endmodule
`default_nettype wire

// ---- sim/tb_inverse_mux_control_status.sv ----
// bench for the bonding register bank, driven over axi4-lite
// assumes imxcs_top and the far-end model on one 25 mhz clock
`timescale 1ns/1ps
`default_nettype none
module tb_inverse_mux_control_status;
	import imxcs_pkg::*;
	logic clk_sys, rst_b, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv, pulse, rclr, wclr, irq;
	logic [7:0] awa, ara, frame_cmd, skew_cmd;
	logic [31:0] wd, rdat, got;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] cfg [5] = '{8'h40, 8'h20, 8'h10, 8'h0a, 8'hff};
	imxcs_ctrl_t ctrl;
	imxcs_status_t stat;
	int error_cnt, num_checks, cyc, pulse_cnt, p0;
	imxcs_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .status_in(stat),
		.ctrl_out(ctrl), .link_start_pulse(pulse), .txq_read_ptr_clear(rclr),
		.txq_write_ptr_clear(wclr), .irq(irq));
	imxcs_far_model u_far (.clk_sys(clk_sys), .rst_b(rst_b), .link_start_pulse(pulse),
		.member_links(ctrl.member_links), .frame_cmd(frame_cmd), .skew_cmd(skew_cmd),
		.status_out(stat));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic end_sim();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (pulse === 1'b1) pulse_cnt++;
		// whole run needs well under 2000 cycles
		if (cyc == 5000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
			error_cnt++;
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awa <= {idx[5:0], 2'b00};
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk_sys);
			if (!aw_ok && awr === 1'b1) begin
				aw_ok = 1'b1;
				awv <= 1'b0;
			end
			if (!w_ok && wr_r === 1'b1) begin
				w_ok = 1'b1;
				wv <= 1'b0;
			end
		end
		bry <= 1'b1;
		do @(posedge clk_sys); while (bv !== 1'b1);
		resp = bresp;
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx);
		ara <= {idx[5:0], 2'b00};
		arv <= 1'b1;
		do @(posedge clk_sys); while (arr !== 1'b1);
		arv <= 1'b0;
		rry <= 1'b1;
		do @(posedge clk_sys); while (rv !== 1'b1);
		got = rdat;
		resp = rresp;
		rry <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
		rd(idx);
		chk(got, e);
		chk(32'(resp), 32'(RESP_OKAY));
	endtask
	initial begin
		rst_b = 1'b0;
		{awv, wv, bry, arv, rry} = 5'h00;
		{awa, ara, frame_cmd, skew_cmd, wd} = 64'h0;
		wt(5);
		rst_b <= 1'b1;
		wt(1);
		chk(32'(ctrl), 32'h0);
		for (int i = 8'h16; i < 8'h20; i++)
			rdc(8'(i), (8'(i) == IDX_COMMAND) ? 32'(RST_COMMAND) : 32'(RST_ZERO));
		rdc(IDX_QPTR_CLEAR, 32'h0);
		rd(8'h20);
		chk({got[29:0], resp}, 32'(RESP_SLVERR));
		wr(8'h21, 32'h1);
		chk(32'(resp), 32'(RESP_SLVERR));
		wr(IDX_SKEW, 32'hff);
		chk(32'(resp), 32'(RESP_OKAY));
		rdc(IDX_SKEW, 32'h0);
		for (int v = 1; v < 4; v++) begin
			wr(IDX_QPTR_CLEAR, 32'(v));
			chk({30'h0, rclr, wclr}, 32'(v));
			wr(IDX_QPTR_CLEAR, 32'h0);
			chk({30'h0, rclr, wclr}, 32'h0);
		end
		foreach (cfg[k]) begin
			wr(IDX_CONFIG, 32'(cfg[k]));
			chk(32'(ctrl), 32'(cfg[k] & 8'h7f));
			rdc(IDX_CONFIG, 32'(cfg[k] & 8'h7f));
		end
		wr(IDX_CONFIG, 32'h35);
		p0 = pulse_cnt;
		wr(IDX_COMMAND, 32'h55);
		rdc(IDX_COMMAND, 32'(CMD_NOP));
		chk(32'(pulse_cnt), 32'(p0));
		wr(IDX_COMMAND, 32'(CMD_LINK_START));
		rdc(IDX_COMMAND, 32'(CMD_LINK_START));
		chk(32'(pulse_cnt), 32'(p0 + 1));
		wr(IDX_COMMAND, 32'(CMD_NOP));
		wt(8);
		rdc(IDX_SYNC_STATUS, 32'h55);
		rdc(IDX_SYNC_LATCHED, 32'h55);
		wr(IDX_SYNC_IRQ_EN, 32'h02);
		wt(2);
		chk(32'(irq), 32'h0);
		wr(IDX_SYNC_IRQ_EN, 32'h40);
		wt(2);
		chk(32'(irq), 32'h1);
		wr(IDX_CONFIG, 32'h30);
		wt(2);
		rdc(IDX_SYNC_STATUS, 32'h0);
		rdc(IDX_SYNC_LATCHED, 32'h55);
		wr(IDX_SYNC_LATCHED, 32'hff);
		rdc(IDX_SYNC_LATCHED, 32'h0);
		chk(32'(irq), 32'h0);
		skew_cmd <= 8'd31;
		wt(2);
		rdc(IDX_SKEW, 32'd31);
		rdc(IDX_SKEW_LATCHED, 32'h0);
		skew_cmd <= 8'd32;
		wt(3);
		rdc(IDX_SKEW_LATCHED, 32'h1);
		chk(32'(irq), 32'h0);
		wr(IDX_SKEW_IRQ_EN, 32'h1);
		wt(2);
		chk(32'(irq), 32'h1);
		skew_cmd <= 8'h00;
		wt(2);
		wr(IDX_SKEW_LATCHED, 32'h1);
		wt(2);
		chk(32'(irq), 32'h0);
		frame_cmd <= 8'h81;
		wt(3);
		frame_cmd <= 8'h00;
		rdc(IDX_FRAME_LATCHED, 32'h81);
		wr(IDX_FRAME_IRQ_EN, 32'h7e);
		wt(2);
		chk(32'(irq), 32'h0);
		wr(IDX_FRAME_IRQ_EN, 32'h01);
		wt(2);
		chk(32'(irq), 32'h1);
		wr(IDX_CONFIG, 32'h20);
		chk(32'(ctrl), 32'h20);
		wr(IDX_COMMAND, 32'(CMD_LINK_START));
		rst_b <= 1'b0;
		wt(2);
		rst_b <= 1'b1;
		wt(1);
		chk({31'h0, irq}, 32'h0);
		chk(32'(ctrl), 32'h0);
		rdc(IDX_COMMAND, 32'(RST_COMMAND));
		rdc(IDX_FRAME_LATCHED, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
